// ---- rtl/hps_pkg.sv ----
package hps_pkg;
   typedef struct packed {
      logic undervoltage_input;
      logic overvoltage_input;
      logic board_present_n;
      logic on_input;
      logic timer_low_comparator;
      logic timer_high_comparator;
      logic current_limit;
      logic high_current;
      logic power_good_comparator;
      logic general_input_comparator;
      logic supply_lockout_detector;
      logic internal_lockout_detector;
   } hps_sense_t;
   typedef struct packed {
      logic gate_charge;
      logic gate_slow_off;
      logic gate_fast_off;
      logic timer_charge;
      logic timer_discharge;
   } hps_gate_t;
   typedef struct packed {
      logic [11:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [11:0] araddr;
      logic arvalid;
      logic rready;
   } hps_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } hps_axi_rsp_t;
   typedef enum logic [3:0] {
      HPS_POR = 4'b0001,
      HPS_QUAL = 4'b0010,
      HPS_OFF = 4'b0100,
      HPS_ON = 4'b1000
   } hps_state_t;
endpackage : hps_pkg

// ---- rtl/hps_regs.svh ----
`ifndef HPS_REGS_SVH
`define HPS_REGS_SVH
// register byte offsets
`define HPS_CTRL_OFS 12'h000
`define HPS_STAT_OFS 12'h004
`define HPS_FAULT_OFS 12'h008
`define HPS_ADC_OFS 12'h00c
`define HPS_ADDR_OFS 12'h010
// control fields
`define HPS_C_OV_RETRY 0
`define HPS_C_UV_RETRY 1
`define HPS_C_OC_RETRY 2
`define HPS_C_SW_ON 3
`define HPS_C_GP_MODE 6
`define HPS_CTRL_RST 8'h07
// status / fault fields
`define HPS_F_OV 0
`define HPS_F_UV 1
`define HPS_F_OC 2
`define HPS_F_PB 3
`define HPS_F_BD 4
// timing
`define HPS_CLK_MHZ 125
`define HPS_QUAL_MS 100
`define HPS_QUAL_CYC (`HPS_QUAL_MS * 1000 * `HPS_CLK_MHZ)
`define HPS_SUP_US 5
`define HPS_SUP_CYC (`HPS_SUP_US * `HPS_CLK_MHZ + 1)
`define HPS_INT_US 1
`define HPS_INT_CYC (`HPS_INT_US * `HPS_CLK_MHZ + 1)
`define HPS_POR_US 60
`define HPS_POR_CYC (`HPS_POR_US * `HPS_CLK_MHZ)
`define HPS_ADC_CYC 12500000
`endif

// ---- rtl/hps_sequencer.sv ----
// Summary of operation
// R01 - internal supply rising clears all faults and sets control defaults
// R02 - turn-on needs supply in window and board present for 100 ms
// R03 - after qualification switch follows on input or bus command
// R04 - on input low or bus off command turns switch off slowly
// R05 - overvoltage, undervoltage, overcurrent trip or board removal turn off
// R06 - writing one to a fault flag without autoretry turns off
// R07 - supply low 5 us or internal low 1 us gives fast shutdown
// R08 - timer high trip turns off, sets overcurrent present and fault
// R09 - timer low clears present flag; restart without autoretry needs fault cleared
// R10 - overcurrent autoretry restarts after cooldown, fault flag stays set
// R11 - high current forces gate off at once, independent of timer
// R12 - default mode releases general pin while feedback is good
// R13 - general pin may be open-drain output or input via comparator
// R14 - bus address decoded from three ternary select inputs, 27 values
// R15 - host polls converter results and fault status over the bus
// R16 - 8-bit converter muxes aux input, source and sense voltage
// R17 - supply fault cleared for 100 ms allows restart with autoretry
// R18 - latched faults hold off without autoretry; else present flags
// R19 - turn-off by on input or control bit falling clears faults
// R20 - board present low 100 ms copies on input into control bit
// R21 - delays counted on system clock; comparators synchronised first
// R22 - any precondition dropping restarts the qualification count
`timescale 1ns/1ps
`default_nettype none
`include "hps_regs.svh"
module hps_sequencer #(
   parameter int QUAL_CYC = `HPS_QUAL_CYC,
   parameter int ADC_CYC = `HPS_ADC_CYC
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire hps_pkg::hps_sense_t sense,
   input wire logic [1:0] addr_select_0,
   input wire logic [1:0] addr_select_1,
   input wire logic [1:0] addr_select_2,
   input wire logic [7:0] adc_result,
   input wire logic adc_done,
   output logic [1:0] adc_mux_sel,
   output logic adc_start,
   output hps_pkg::hps_gate_t gate,
   output logic gp_out,
   output logic gp_oe_n,
   input wire hps_pkg::hps_axi_req_t axi_req,
   output hps_pkg::hps_axi_rsp_t axi_rsp
);
   import hps_pkg::*;
   if (QUAL_CYC < 2 || ADC_CYC < 2) begin : g_bad_cfg
      $error("counts too small");
   end

   hps_sense_t s1, s2;
   hps_state_t state;
   logic [7:0] ctrl;
   logic [4:0] fault;
   logic [31:0] qcnt, rcnt, acnt;
   logic [9:0] vcnt, icnt;
   logic [7:0] adc_src, adc_aux, adc_cs;
   logic [6:0] bus_addr;
   logic on_d, bd_d, sw_d, oc_latch, fast, qual_ok, bd_copied;
   logic aw_hold, w_hold, aw_rdy, w_rdy, b_vld, ar_rdy, r_vld;
   logic [1:0] b_resp, r_resp;
   logic [11:0] awa;
   logic [31:0] wd, r_data;
   logic por_done;
   logic [15:0] pcnt;

   // comparators may toggle anywhere in the cycle; two flops each
   always_ff @(posedge sys_clk or posedge sys_rst) begin // R21
      if (sys_rst) begin
         s1 <= '0;
         s2 <= '0;
      end else begin
         s1 <= sense;
         s2 <= s1;
      end
   end

   wire uv_bad = !s2.undervoltage_input;
   wire ov_bad = s2.overvoltage_input;
   wire bd_out = s2.board_present_n;
   wire pre_ok = !uv_bad && !ov_bad && !bd_out;
   // internal supply rising: sys_rst, lockout reading high, then a 60 us pulse once lockout reads low
   wire por = !por_done;

   always_ff @(posedge sys_clk or posedge sys_rst) begin // R01
      if (sys_rst) begin
         pcnt <= '0;
         por_done <= 1'b0;
      end else if (s2.internal_lockout_detector) begin
         pcnt <= '0;
         por_done <= 1'b0;
      end else if (pcnt == 16'(`HPS_POR_CYC)) begin
         por_done <= 1'b1;
      end else begin
         pcnt <= pcnt + 16'h0001;
      end
   end

   // fast shutdown qualifiers
   always_ff @(posedge sys_clk or posedge sys_rst) begin // R07
      if (sys_rst) begin
         vcnt <= '0;
         icnt <= '0;
      end else begin
         vcnt <= !s2.supply_lockout_detector ? '0 :
            (vcnt == 10'(`HPS_SUP_CYC) ? vcnt : vcnt + 10'h001);
         icnt <= !s2.internal_lockout_detector ? '0 :
            (icnt == 10'(`HPS_INT_CYC) ? icnt : icnt + 10'h001);
      end
   end
   assign fast = (vcnt == 10'(`HPS_SUP_CYC)) ||
      (icnt == 10'(`HPS_INT_CYC)) || s2.high_current; // R07 R11

   // qualification counter restarts on any drop
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         qcnt <= '0;
      end else if (por || !pre_ok) begin // R22
         qcnt <= '0;
      end else if (qcnt != 32'(QUAL_CYC)) begin // R02
         qcnt <= qcnt + 32'h1;
      end
   end
   assign qual_ok = (qcnt == 32'(QUAL_CYC));

   // supply window held good for the retry delay
   always_ff @(posedge sys_clk or posedge sys_rst) begin // R17
      if (sys_rst) begin
         rcnt <= '0;
      end else if (uv_bad || ov_bad) begin
         rcnt <= '0;
      end else if (rcnt != 32'(QUAL_CYC)) begin
         rcnt <= rcnt + 32'h1;
      end
   end

   wire wr_go = aw_hold && w_hold && !b_vld;
   wire wr_ctrl = wr_go && awa == `HPS_CTRL_OFS;
   wire wr_fault = wr_go && awa == `HPS_FAULT_OFS;
   wire on_fall = on_d && !s2.on_input;
   wire on_rise = !on_d && s2.on_input;
   wire oc_trip = state == HPS_ON && s2.timer_high_comparator;
   wire [4:0] present = {1'b0, !s2.power_good_comparator, oc_latch,
      uv_bad, ov_bad};
   // hold-off: latched faults without retry, present flags with retry
   wire hold_ov = ctrl[`HPS_C_OV_RETRY] ? present[0] : fault[0]; // R18
   wire hold_uv = ctrl[`HPS_C_UV_RETRY] ? present[1] : fault[1];
   wire hold_oc = ctrl[`HPS_C_OC_RETRY] ? oc_latch : fault[2];
   wire held = hold_ov || hold_uv || hold_oc || oc_latch;
   wire retry_wait = rcnt != 32'(QUAL_CYC);

   // control register: switch bit follows pin edges and bus writes
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= `HPS_CTRL_RST;
         on_d <= 1'b0;
         bd_d <= 1'b1;
         bd_copied <= 1'b0;
      end else if (por) begin // R01
         ctrl <= `HPS_CTRL_RST;
         on_d <= s2.on_input;
         bd_d <= bd_out;
         bd_copied <= 1'b0;
      end else begin
         on_d <= s2.on_input;
         bd_d <= bd_out;
         if (bd_out) bd_copied <= 1'b0;
         if (wr_ctrl && axi_req.wstrb[0]) begin // R03 R04
            ctrl <= wd[7:0];
         end else if (qual_ok && !bd_copied) begin // R20 R03
            ctrl[`HPS_C_SW_ON] <= s2.on_input;
            bd_copied <= 1'b1;
         end else if (on_rise || on_fall) begin // R03 R04
            ctrl[`HPS_C_SW_ON] <= s2.on_input;
         end
      end
   end

   // fault flags: set wins over clear, still-present ones stay
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fault <= '0;
         sw_d <= 1'b0;
      end else if (por) begin // R01
         fault <= '0;
         sw_d <= 1'b0;
      end else begin
         sw_d <= ctrl[`HPS_C_SW_ON];
         if (sw_d && !ctrl[`HPS_C_SW_ON]) begin // R19
            fault <= present;
         end else if (!bd_out && bd_d) begin
            fault <= {1'b1, present[3:0]};
         end else begin
            for (int i = 0; i < 5; i++) begin
               if (wr_fault && axi_req.wstrb[0]) begin
                  // a written one latches the flag, which holds off only for OV, UV or OC with its retry bit clear
                  fault[i] <= wd[i] | present[i]; // R06 R18
               end else begin
                  fault[i] <= fault[i] | present[i];
               end
            end
            if (bd_out != bd_d) fault[`HPS_F_BD] <= 1'b1;
            if (oc_trip) fault[`HPS_F_OC] <= 1'b1; // R08
         end
      end
   end

   // overcurrent present flag and timer control
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         oc_latch <= 1'b0;
      end else if (por) begin
         oc_latch <= 1'b0;
      end else if (oc_trip) begin // R08
         oc_latch <= 1'b1;
      end else if (s2.timer_low_comparator) begin // R09 R10
         oc_latch <= 1'b0;
      end
   end

   // writing one to a fault bit without retry forces off
   wire fault_kill = wr_fault && axi_req.wstrb[0] && // R06
      ((wd[0] && !ctrl[`HPS_C_OV_RETRY]) ||
      (wd[1] && !ctrl[`HPS_C_UV_RETRY]) ||
      (wd[2] && !ctrl[`HPS_C_OC_RETRY]));

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= HPS_POR;
      end else if (por) begin
         state <= HPS_POR;
      end else begin
         unique case (state)
            HPS_POR: state <= HPS_QUAL;
            HPS_QUAL: if (qual_ok) state <= HPS_OFF; // R02
            HPS_OFF: begin
               if (!pre_ok) state <= HPS_QUAL; // R22
               else if (ctrl[`HPS_C_SW_ON] && !held && !retry_wait &&
                  !fast) state <= HPS_ON; // R03 R09 R10 R17
            end
            HPS_ON: begin
               if (bd_out) state <= HPS_QUAL; // R05
               else if (!ctrl[`HPS_C_SW_ON] || uv_bad || ov_bad ||
                  oc_trip || fault_kill || fast) state <= HPS_OFF; // R04 R05
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gate <= '{default: 1'b0};
      end else begin
         gate.gate_charge <= state == HPS_ON && !fast;
         gate.gate_slow_off <= state != HPS_ON && !fast; // R04
         gate.gate_fast_off <= fast; // R07 R11
         gate.timer_charge <= state == HPS_ON && s2.current_limit; // R08
         gate.timer_discharge <= oc_latch; // R09
      end
   end

   // general pin: power good release, output, or input
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gp_oe_n <= 1'b0;
         gp_out <= 1'b0;
      end else begin
         gp_out <= 1'b0;
         unique case (ctrl[7:6])
            2'b00: gp_oe_n <= s2.power_good_comparator; // R12
            2'b01: gp_oe_n <= !s2.power_good_comparator; // R13
            2'b10: gp_oe_n <= ctrl[5]; // R13
            2'b11: gp_oe_n <= 1'b1; // R13
         endcase
      end
   end

   // ternary select: 0 low, 1 open, 2 high; base-3 index
   always_ff @(posedge sys_clk or posedge sys_rst) begin // R14
      if (sys_rst) begin
         bus_addr <= '0;
      end else begin
         bus_addr <= 7'(addr_select_2 * 9 + addr_select_1 * 3 +
            addr_select_0);
      end
   end

   // converter round robin over three inputs
   always_ff @(posedge sys_clk or posedge sys_rst) begin // R16
      if (sys_rst) begin
         acnt <= '0;
         adc_mux_sel <= 2'h0;
         adc_start <= 1'b0;
         adc_aux <= '0;
         adc_src <= '0;
         adc_cs <= '0;
      end else begin
         adc_start <= acnt == 32'h0;
         acnt <= (acnt == 32'(ADC_CYC - 1)) ? '0 : acnt + 32'h1;
         if (adc_done) begin
            unique case (adc_mux_sel)
               2'h0: adc_aux <= adc_result;
               2'h1: adc_src <= adc_result;
               default: adc_cs <= adc_result;
            endcase
            adc_mux_sel <= adc_mux_sel == 2'h2 ? 2'h0 : adc_mux_sel + 2'h1;
         end
      end
   end

   // axi-lite slave, one write and one read at a time
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         awa <= '0;
         wd <= '0;
         aw_rdy <= 1'b0;
         w_rdy <= 1'b0;
         b_vld <= 1'b0;
         b_resp <= 2'h0;
      end else begin
         aw_rdy <= !aw_hold && !aw_rdy;
         w_rdy <= !w_hold && !w_rdy;
         if (axi_req.awvalid && aw_rdy) begin
            aw_hold <= 1'b1;
            awa <= axi_req.awaddr;
            aw_rdy <= 1'b0;
         end
         if (axi_req.wvalid && w_rdy) begin
            w_hold <= 1'b1;
            wd <= axi_req.wdata;
            w_rdy <= 1'b0;
         end
         if (wr_go) begin
            b_vld <= 1'b1;
            b_resp <= (awa == `HPS_CTRL_OFS ||
               awa == `HPS_FAULT_OFS) ? 2'h0 : 2'h2;
         end else if (b_vld && axi_req.bready) begin
            b_vld <= 1'b0;
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin // R15
      if (sys_rst) begin
         ar_rdy <= 1'b0;
         r_vld <= 1'b0;
         r_data <= '0;
         r_resp <= 2'h0;
      end else begin
         ar_rdy <= !r_vld && !ar_rdy;
         if (axi_req.arvalid && ar_rdy) begin
            ar_rdy <= 1'b0;
            r_vld <= 1'b1;
            r_resp <= 2'h0;
            unique case (axi_req.araddr)
               `HPS_CTRL_OFS: r_data <= {24'h0, ctrl};
               `HPS_STAT_OFS: r_data <= {23'h0, state == HPS_ON, 2'h0,
                  s2.general_input_comparator, !bd_out, present[3:0]}; // R13
               `HPS_FAULT_OFS: r_data <= {27'h0, fault};
               `HPS_ADC_OFS: r_data <= {8'h0, adc_cs, adc_src, adc_aux};
               `HPS_ADDR_OFS: r_data <= {25'h0, bus_addr};
               default: begin
                  r_data <= '0;
                  r_resp <= 2'h2;
               end
            endcase
         end else if (r_vld && axi_req.rready) begin
            r_vld <= 1'b0;
         end
      end
   end
   // one driver for the whole response struct, every field a flop
   assign axi_rsp = {aw_rdy, w_rdy, b_resp, b_vld, ar_rdy, r_data, r_resp,
      r_vld};
endmodule : hps_sequencer
`default_nettype wire

// ---- verification/hps_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none
module hps_far_side #(
   parameter int CHG_STEP = 8,
   parameter int ADC_DLY = 3
) (
   input wire logic sys_clk,
   input wire hps_pkg::hps_gate_t gate,
   input wire logic [1:0] adc_mux_sel,
   input wire logic adc_start,
   output logic timer_low,
   output logic timer_high,
   output logic power_good,
   output logic [7:0] adc_result,
   output logic adc_done
);
   import hps_pkg::*;
   int lvl = 0;
   int dly = 0;
   logic [1:0] mux = 2'h0;
   logic pg_q = 1'b0;
   logic done_q = 1'b0;
   logic [7:0] res_q = 8'h00;
   // charge outruns discharge, so cooldown is much longer than the trip
   always_ff @(posedge sys_clk) begin
      if (gate.timer_charge) lvl <= lvl + CHG_STEP;
      else if (gate.timer_discharge && lvl > 0) lvl <= lvl - 1;
   end
   assign timer_high = lvl >= 20 * CHG_STEP;
   assign timer_low = lvl <= 2 * CHG_STEP;
   always_ff @(posedge sys_clk) pg_q <= gate.gate_charge;
   assign power_good = pg_q;
   always_ff @(posedge sys_clk) begin
      if (adc_start) begin
         mux <= adc_mux_sel;
         dly <= ADC_DLY;
      end else if (dly > 0) dly <= dly - 1;
   end
   // result bus is junk outside the done strobe
   always_ff @(posedge sys_clk) begin
      done_q <= dly == 1;
      res_q <= dly == 1 ? 8'h10 + {6'h0, mux} : ~res_q;
   end
   assign adc_done = done_q;
   assign adc_result = res_q;
endmodule : hps_far_side
`default_nettype wire

// ---- verification/hps_sequencer_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module hps_sequencer_monitor #(
   parameter int QUAL_CYC = 200,
   parameter int ADC_CYC = 50
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire hps_pkg::hps_sense_t sense,
   input wire logic [1:0] addr_select_0,
   input wire logic [1:0] addr_select_1,
   input wire logic [1:0] addr_select_2,
   input wire logic [7:0] adc_result,
   input wire logic adc_done,
   input wire logic [1:0] adc_mux_sel,
   input wire logic adc_start,
   input wire hps_pkg::hps_gate_t gate,
   input wire logic gp_out,
   input wire logic gp_oe_n,
   input wire hps_pkg::hps_axi_req_t axi_req,
   input wire hps_pkg::hps_axi_rsp_t axi_rsp
);
   import hps_pkg::*;
   int qual_cnt;
   int sup_cnt;
   // counted at the pins, so the synchroniser delay only adds margin
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) qual_cnt <= 0;
      else if (sense.undervoltage_input && !sense.overvoltage_input &&
         !sense.board_present_n) qual_cnt <= qual_cnt + 1;
      else qual_cnt <= 0;
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) sup_cnt <= 0;
      else if (sense.supply_lockout_detector) sup_cnt <= sup_cnt + 1;
      else sup_cnt <= 0;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   AST_QUAL: assert property ($rose(gate.gate_charge) |-> qual_cnt >= QUAL_CYC)
      else $error("switch on before a full qualifying window");
   AST_HICUR: assert property (sense.high_current [*4] |->
      gate.gate_fast_off && !gate.gate_charge)
      else $error("high current did not force the gate off");
   AST_BOARD: assert property (sense.board_present_n [*6] |-> !gate.gate_charge)
      else $error("gate charged with board absent");
   AST_OV: assert property (sense.overvoltage_input [*6] |-> !gate.gate_charge)
      else $error("gate charged during overvoltage");
   AST_UV: assert property (!sense.undervoltage_input [*6] |-> !gate.gate_charge)
      else $error("gate charged during undervoltage");
   AST_TRIP: assert property (sense.timer_high_comparator [*6] |->
      !gate.gate_charge)
      else $error("timer trip left the switch on");
   AST_SUP: assert property (sup_cnt > 640 |-> gate.gate_fast_off)
      else $error("no fast shutdown on long supply dip");
   AST_EXCL: assert property (gate.gate_charge |-> !gate.gate_slow_off)
      else $error("charge and slow pull-down together");
   AST_RDLAT: assert property (axi_req.arvalid && axi_rsp.arready |=>
      axi_rsp.rvalid)
      else $error("read answer late");
endmodule : hps_sequencer_monitor
bind hps_sequencer hps_sequencer_monitor #(
   .QUAL_CYC(QUAL_CYC),
   .ADC_CYC(ADC_CYC)
) mon_u (
   .sys_clk(sys_clk),
   .sys_rst(sys_rst),
   .sense(sense),
   .addr_select_0(addr_select_0),
   .addr_select_1(addr_select_1),
   .addr_select_2(addr_select_2),
   .adc_result(adc_result),
   .adc_done(adc_done),
   .adc_mux_sel(adc_mux_sel),
   .adc_start(adc_start),
   .gate(gate),
   .gp_out(gp_out),
   .gp_oe_n(gp_oe_n),
   .axi_req(axi_req),
   .axi_rsp(axi_rsp)
);
`default_nettype wire

// ---- verification/hps_sequencer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module hps_sequencer_test;
   import hps_pkg::*;
   localparam int QUAL = 200;
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] e;
      logic [31:0] m;
      logic [1:0] r;
   } hps_row_t;
   logic sys_clk, sys_rst, uv, ov, bpn, on_in, cl, hc, gic, sup, intl;
   logic t_lo, t_hi, pg, adc_done, adc_start, gp_out, gp_oe_n;
   logic [7:0] adc_result;
   logic [1:0] mux, asel, rs_v;
   logic [31:0] rd_v;
   hps_sense_t sense;
   hps_gate_t gate;
   hps_axi_req_t req;
   hps_axi_rsp_t rsp;
   int err_total, checks_done, i;
   hps_row_t rows [6] = '{'{12'h000, 32'h07, 32'hff, 2'h0},
      '{12'h004, 32'h0, 32'h117, 2'h0}, '{12'h008, 32'h0, 32'h1f, 2'h0},
      '{12'h00c, 32'h121110, 32'hffffff, 2'h0},
      '{12'h010, 32'd5, 32'hff, 2'h0}, '{12'h014, 32'h0, 32'h0, 2'h2}};
   assign sense = {uv, ov, bpn, on_in, t_lo, t_hi, cl, hc, pg, gic, sup, intl};
   hps_sequencer #(.QUAL_CYC(QUAL), .ADC_CYC(50)) dut_u (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .sense(sense), .addr_select_0(asel),
      .addr_select_1(~asel), .addr_select_2(asel ^ 2'h2),
      .adc_result(adc_result),
      .adc_done(adc_done), .adc_mux_sel(mux), .adc_start(adc_start),
      .gate(gate), .gp_out(gp_out), .gp_oe_n(gp_oe_n), .axi_req(req),
      .axi_rsp(rsp));
   hps_far_side far_u (.sys_clk(sys_clk), .gate(gate), .adc_mux_sel(mux),
      .adc_start(adc_start), .timer_low(t_lo), .timer_high(t_hi),
      .power_good(pg), .adc_result(adc_result), .adc_done(adc_done));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic tmo;
      chk(32'h0, 32'h1);
      close_out();
   endtask : tmo
   task automatic wait_bit(input int sel, input logic v, input int lim);
      int n;
      for (n = 0; n < lim; n++) begin
         @(posedge sys_clk);
         if ((sel == 0 ? gate.gate_charge : gate.gate_fast_off) === v) return;
      end
      tmo();
   endtask : wait_bit
   // bready and rready stay high, so a response is taken when first seen
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge sys_clk);
         if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
         if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
         if (rsp.bvalid === 1'b1) break;
      end
      rs_v = rsp.bresp;
      if (n == 100) tmo();
   endtask : wr
   task automatic rd(input logic [11:0] a);
      int n;
      req.araddr <= a;
      req.arvalid <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge sys_clk);
         if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
         if (rsp.rvalid === 1'b1) break;
      end
      rd_v = rsp.rdata;
      rs_v = rsp.rresp;
      if (n == 100) tmo();
   endtask : rd
   initial begin
      {sys_rst, uv, bpn, on_in} = 4'hf;
      {ov, cl, hc, gic, sup, intl} = 6'h0;
      asel = 2'd2;
      req = '0;
      req.bready = 1'b1;
      req.rready = 1'b1;
      err_total = 0;
      checks_done = 0;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (800) @(posedge sys_clk);
      foreach (rows[k]) begin
         rd(rows[k].a);
         chk(rd_v & rows[k].m, rows[k].e);
         chk({30'h0, rs_v}, {30'h0, rows[k].r});
      end
      wr(12'h004, 32'h1);
      chk({30'h0, rs_v}, 32'h2);
      $display("register table done");
      // the power-on pulse must be over before the board goes in
      repeat (7000) @(posedge sys_clk);
      bpn <= 1'b0;
      repeat (150) @(posedge sys_clk);
      bpn <= 1'b1;
      @(posedge sys_clk);
      bpn <= 1'b0;
      wait_bit(0, 1'b1, QUAL + 100);
      rd(12'h000);
      chk(rd_v[3], 1'b1);
      repeat (10) @(posedge sys_clk);
      chk({gp_out, gp_oe_n}, 2'b01);
      $display("qualified turn-on done");
      cl <= 1'b1;
      wait_bit(0, 1'b0, 300);
      cl <= 1'b0;
      rd(12'h004);
      chk(rd_v[2], 1'b1);
      rd(12'h008);
      chk(rd_v[2], 1'b1);
      wait_bit(0, 1'b1, QUAL + 400);
      rd(12'h008);
      chk(rd_v[2], 1'b1);
      rd(12'h004);
      chk(rd_v[2], 1'b0);
      $display("overcurrent retry done");
      wr(12'h000, 32'h07);
      wait_bit(0, 1'b0, 50);
      chk(gate.gate_slow_off, 1'b1);
      rd(12'h008);
      chk(rd_v[4:0], 5'h0);
      repeat (10) @(posedge sys_clk);
      chk(gp_oe_n, 1'b0);
      wr(12'h000, 32'h0b);
      wait_bit(0, 1'b1, 50);
      wr(12'h008, 32'h04);
      wait_bit(0, 1'b0, 50);
      repeat (20) @(posedge sys_clk);
      chk(gate.gate_charge, 1'b0);
      wr(12'h008, 32'h00);
      wait_bit(0, 1'b1, QUAL + 100);
      wr(12'h000, 32'h4b);
      repeat (4) @(posedge sys_clk);
      chk(gp_oe_n, 1'b0);
      wr(12'h000, 32'hab);
      gic <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk(gp_oe_n, 1'b1);
      wr(12'h000, 32'hcb);
      rd(12'h004);
      chk(rd_v[5], 1'b1);
      wr(12'h000, 32'h0b);
      on_in <= 1'b0;
      wait_bit(0, 1'b0, 50);
      on_in <= 1'b1;
      wait_bit(0, 1'b1, 50);
      $display("bus and pin control done");
      hc <= 1'b1;
      wait_bit(1, 1'b1, 10);
      hc <= 1'b0;
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      wait_bit(0, 1'b1, QUAL + 7800);
      rd(12'h008);
      chk(rd_v[2:0], 3'h0);
      for (i = 0; i < 2; i++) begin
         if (i == 0) uv <= 1'b0;
         else ov <= 1'b1;
         wait_bit(0, 1'b0, 50);
         rd(12'h004);
         chk(rd_v[1 - i], 1'b1);
         uv <= 1'b1;
         ov <= 1'b0;
         wait_bit(0, 1'b1, QUAL + 100);
      end
      $display("supply window faults done");
      sup <= 1'b1;
      repeat (600) @(posedge sys_clk);
      chk(gate.gate_fast_off, 1'b0);
      wait_bit(1, 1'b1, 60);
      sup <= 1'b0;
      $display("fast shutdown done");
      close_out();
   end
endmodule : hps_sequencer_test
`default_nettype wire
